/* rtl/atwc_cfg.svh */
// Register map, field positions, reset values and timing counts
`ifndef ATWC_CFG_SVH
`define ATWC_CFG_SVH

`define ATWC_ADDR_W          13
`define ATWC_MAIN_ADDR       13'h1fc0
`define ATWC_CALC_ADDR       13'h1fc1
`define ATWC_ANG_LO_ADDR     13'h1fc2
`define ATWC_ANG_HI_ADDR     13'h1fc3
`define ATWC_AMP_ADDR        13'h1fc4
`define ATWC_PRD_ADDR        13'h1fc5
`define ATWC_EDT_ADDR        13'h1fc6
`define ATWC_WAVE_ADDR       13'h1fc7
`define ATWC_STAT_ADDR       13'h1fc8
`define ATWC_MASK_ADDR       13'h1fc9

`define ATWC_MAIN_RST        8'h00
`define ATWC_CALC_RST        2'h0
`define ATWC_B_DIR           7
`define ATWC_B_ORDER         6
`define ATWC_B_CKHI          5
`define ATWC_B_CKLO          4
`define ATWC_B_MOD3          3
`define ATWC_B_XFER          2
`define ATWC_B_WAVEFORM_CALC_ENABLE        1
`define ATWC_B_TEN           0
`define ATWC_B_SWST          3
`define ATWC_B_BUSY          2
`define ATWC_B_SYNC          1
`define ATWC_B_IRQSEL        0
`define ATWC_B_EV_ANGLE      0
`define ATWC_B_EV_CALC       1

`define ATWC_ANGLE_LAST      9'h17f
`define ATWC_ANGLE_HALF      9'h0c0
`define ATWC_OFS_120         10'h080
`define ATWC_OFS_240         10'h100
`define ATWC_ANGLE_MOD       10'h180
`define ATWC_TABLE_DEPTH     384
`define ATWC_DUTY_W          10

`endif

/* rtl/atwc_pkg.sv */
// Types for the angle timer and waveform control block
package atwc_pkg;
	typedef enum logic [1:0] {
		ATWC_IDLE = 2'b00,
		ATWC_PH_U = 2'b01,
		ATWC_PH_V = 2'b10,
		ATWC_PH_W = 2'b11
	} atwc_state_e;
	typedef logic [8:0] atwc_angle_t;
endpackage : atwc_pkg

/* rtl/atwc_ctrl.sv */
// Angle timer, waveform arithmetic control and register slave
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
`include "atwc_cfg.svh"

module atwc_ctrl
	import atwc_pkg::*;
(
	input  wire logic                      mclk,
	input  wire logic                      rst_n,
	input  wire logic [`ATWC_ADDR_W-1:0]   addr,
	input  wire logic [7:0]                wr_data,
	input  wire logic                      wr_en,
	input  wire logic                      rd_en,
	output logic      [7:0]                rd_data,
	output logic                           irq,
	output logic                           angle_irq,
	output logic      [`ATWC_DUTY_W-1:0]   phase_duty_compare_u,
	output logic      [`ATWC_DUTY_W-1:0]   phase_duty_compare_v,
	output logic      [`ATWC_DUTY_W-1:0]   phase_duty_compare_w,
	output logic                           duty_load
);

	logic [7:0]          angle_waveform_main_ctrl;
	logic [1:0]          calc_ctrl_low;
	logic                calc_busy_flag;
	atwc_angle_t         electrical_angle_value;
	logic                angle_hi_latch;
	logic [7:0]          voltage_amplitude;
	logic [7:0]          pwm_period_value;
	logic [7:0]          angle_period;
	logic [1:0]          irq_status;
	logic [1:0]          irq_mask;
	logic [5:0]          prescale;
	logic [7:0]          period_cnt;
	atwc_state_e         state;
	atwc_angle_t         calc_angle;
	logic [`ATWC_DUTY_W-1:0] res_u;
	logic [`ATWC_DUTY_W-1:0] res_v;
	logic                calc_done;
	logic [7:0]          sine_table [0:`ATWC_TABLE_DEPTH-1];

	// Field views
	wire angle_count_direction  = angle_waveform_main_ctrl[`ATWC_B_DIR];
	wire phase_order_sel        = angle_waveform_main_ctrl[`ATWC_B_ORDER];
	wire [1:0] angle_timer_clock_sel =
		angle_waveform_main_ctrl[`ATWC_B_CKHI:`ATWC_B_CKLO];
	wire modulation_type_sel    = angle_waveform_main_ctrl[`ATWC_B_MOD3];
	wire result_transfer_enable = angle_waveform_main_ctrl[`ATWC_B_XFER];
	wire waveform_calc_enable   = angle_waveform_main_ctrl[`ATWC_B_WAVEFORM_CALC_ENABLE];
	wire angle_timer_enable     = angle_waveform_main_ctrl[`ATWC_B_TEN];
	wire angle_sync_calc_enable = calc_ctrl_low[`ATWC_B_SYNC];
	wire angle_irq_source_sel   = calc_ctrl_low[`ATWC_B_IRQSEL];

	// Address decode
	wire sel_main  = (addr == `ATWC_MAIN_ADDR);
	wire sel_calc  = (addr == `ATWC_CALC_ADDR);
	wire sel_alo   = (addr == `ATWC_ANG_LO_ADDR);
	wire sel_ahi   = (addr == `ATWC_ANG_HI_ADDR);
	wire sel_amp   = (addr == `ATWC_AMP_ADDR);
	wire sel_prd   = (addr == `ATWC_PRD_ADDR);
	wire sel_edt   = (addr == `ATWC_EDT_ADDR);
	wire sel_wave  = (addr == `ATWC_WAVE_ADDR);
	wire sel_stat  = (addr == `ATWC_STAT_ADDR);
	wire sel_mask  = (addr == `ATWC_MASK_ADDR);

	wire wr_main  = wr_en & sel_main;
	wire wr_calc  = wr_en & sel_calc;
	wire wr_alo   = wr_en & sel_alo;
	wire [8:0] wr_angle = {angle_hi_latch, wr_data};
	wire angle_set = wr_alo & (wr_angle <= `ATWC_ANGLE_LAST);
	wire timer_stop = wr_main & ~wr_data[`ATWC_B_TEN];

	// Prescaler tick: low 3..6 bits all ones
	wire [5:0] div_mask = {angle_timer_clock_sel == 2'h3,
		angle_timer_clock_sel >= 2'h2,
		angle_timer_clock_sel != 2'h0, 3'h7};
	wire presc_tick = angle_timer_enable & ((prescale & div_mask) == div_mask);
	wire angle_step = presc_tick & (period_cnt == angle_period);

	wire [8:0] angle_up   = (electrical_angle_value == `ATWC_ANGLE_LAST) ? 9'h000
		: electrical_angle_value + 9'h001;
	wire [8:0] angle_down = (electrical_angle_value == 9'h000) ? `ATWC_ANGLE_LAST
		: electrical_angle_value - 9'h001;
	wire [8:0] next_angle = angle_count_direction ? angle_down : angle_up;

	// Calculation triggers
	wire sw_calc_start = wr_calc & wr_data[`ATWC_B_SWST];
	wire sync_trig     = angle_sync_calc_enable & (angle_step | angle_set);
	wire calc_trig     = waveform_calc_enable & (state == ATWC_IDLE)
		& (sw_calc_start | sync_trig);

	// Phase angle for the current step
	wire [9:0] ph_ofs = (state == ATWC_PH_V) ? `ATWC_OFS_120
		: (state == ATWC_PH_W) ? `ATWC_OFS_240 : 10'h000;
	wire [9:0] base   = {1'b0, calc_angle};
	wire [9:0] sum_p  = base + ph_ofs;
	wire [9:0] ang_p  = (sum_p >= `ATWC_ANGLE_MOD) ? sum_p - `ATWC_ANGLE_MOD : sum_p;
	wire [9:0] ang_m  = (base >= ph_ofs) ? base - ph_ofs
		: base + `ATWC_ANGLE_MOD - ph_ofs;
	wire [9:0] ph_ang = phase_order_sel ? ang_m : ang_p;

	// Waveform arithmetic
	wire [7:0]  tab_val = sine_table[ph_ang[8:0]];
	wire [15:0] product = tab_val * voltage_amplitude;
	wire [9:0]  half    = {3'h0, product[15:9]};
	wire [9:0]  prd_ext = {2'h0, pwm_period_value};
	wire        pos_half = (ph_ang[8:0] < `ATWC_ANGLE_HALF);
	wire [9:0]  three_p = prd_ext + half;
	wire [9:0]  three_m = (prd_ext >= half) ? prd_ext - half : 10'h000;
	wire [9:0]  two_ph  = {2'h0, product[15:8]};
	wire [`ATWC_DUTY_W-1:0] result = modulation_type_sel
		? (pos_half ? three_p : three_m) : two_ph;

	// Interrupt events
	wire angle_irq_ev = angle_irq_source_sel ? calc_done : angle_step;
	wire [1:0] ev_set = {calc_done, angle_step};
	wire [1:0] next_status = ev_set
		| (irq_status & ~((wr_en & sel_stat) ? wr_data[1:0] : 2'h0));

	// Read data mux
	wire [7:0] calc_rd = {5'h00, calc_busy_flag, calc_ctrl_low};
	wire [7:0] rd_mux =
		sel_main ? angle_waveform_main_ctrl :
		sel_calc ? calc_rd :
		sel_alo  ? electrical_angle_value[7:0] :
		sel_ahi  ? {7'h00, electrical_angle_value[8]} :
		sel_amp  ? voltage_amplitude :
		sel_prd  ? pwm_period_value :
		sel_edt  ? angle_period :
		sel_stat ? {6'h00, irq_status} :
		sel_mask ? {6'h00, irq_mask} : 8'h00;

	// Control registers
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			angle_waveform_main_ctrl <= `ATWC_MAIN_RST;
			calc_ctrl_low <= `ATWC_CALC_RST;
		end else begin
			if (wr_main)
				angle_waveform_main_ctrl <= wr_data;
			if (wr_calc)
				calc_ctrl_low <= wr_data[1:0];
		end
	end

	// Setting registers
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			angle_hi_latch    <= 1'b0;
			voltage_amplitude <= 8'h00;
			pwm_period_value  <= 8'h00;
			angle_period      <= 8'h00;
			irq_mask          <= 2'h0;
		end else if (wr_en) begin
			if (sel_ahi)
				angle_hi_latch <= wr_data[0];
			if (sel_amp)
				voltage_amplitude <= wr_data;
			if (sel_prd)
				pwm_period_value <= wr_data;
			if (sel_edt)
				angle_period <= wr_data;
			if (sel_mask)
				irq_mask <= wr_data[1:0];
		end
	end

	// Sine table, addressed by the current angle
	always_ff @(posedge mclk) begin
		if (wr_en & sel_wave)
			sine_table[electrical_angle_value] <= wr_data;
	end

	// Angle timer
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			prescale <= 6'h00;
			period_cnt <= 8'h00;
			electrical_angle_value <= 9'h000;
		end else if (!angle_timer_enable) begin
			prescale <= 6'h00;
			period_cnt <= 8'h00;
			// Angle writes hold while stopped so the sine table can be loaded
			if (angle_set)
				electrical_angle_value <= wr_angle;
		end else begin
			prescale <= prescale + 6'h01;
			if (timer_stop)
				period_cnt <= 8'h00;
			else if (presc_tick)
				period_cnt <= angle_step ? 8'h00 : period_cnt + 8'h01;
			if (timer_stop)
				electrical_angle_value <= 9'h000;
			else if (angle_set)
				electrical_angle_value <= wr_angle;
			else if (angle_step)
				electrical_angle_value <= next_angle;
		end
	end

	// Calculation sequencer
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ATWC_IDLE;
			calc_angle <= 9'h000;
			calc_busy_flag <= 1'b0;
			calc_done <= 1'b0;
			res_u <= '0;
			res_v <= '0;
		end else begin
			calc_done <= 1'b0;
			case (state)
				ATWC_IDLE: begin
					if (calc_trig) begin
						state <= ATWC_PH_U;
						calc_angle <= angle_set ? wr_angle : electrical_angle_value;
						calc_busy_flag <= 1'b1;
					end
				end
				ATWC_PH_U: begin
					res_u <= result;
					state <= ATWC_PH_V;
				end
				ATWC_PH_V: begin
					res_v <= result;
					state <= ATWC_PH_W;
				end
				ATWC_PH_W: begin
					state <= ATWC_IDLE;
					calc_busy_flag <= 1'b0;
					calc_done <= 1'b1;
				end
				default: state <= ATWC_IDLE;
			endcase
		end
	end

	// Result transfer to PWM compare registers
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			phase_duty_compare_u <= '0;
			phase_duty_compare_v <= '0;
			phase_duty_compare_w <= '0;
			duty_load <= 1'b0;
		end else begin
			duty_load <= 1'b0;
			if (state == ATWC_PH_W && result_transfer_enable) begin
				phase_duty_compare_u <= res_u;
				phase_duty_compare_v <= res_v;
				phase_duty_compare_w <= result;
				duty_load <= 1'b1;
			end
		end
	end

	// Interrupts and read data
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			irq_status <= 2'h0;
			irq <= 1'b0;
			angle_irq <= 1'b0;
			rd_data <= 8'h00;
		end else begin
			irq_status <= next_status;
			irq <= |(next_status & irq_mask);
			angle_irq <= angle_irq_ev;
			rd_data <= rd_en ? rd_mux : 8'h00;
		end
	end

	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	property p_sw_start;
		sw_calc_start && waveform_calc_enable && state == ATWC_IDLE |=> calc_busy_flag;
	endproperty
	a_sw_start: assert property (p_sw_start) else $error("sw start missed");

	property p_busy_state;
		calc_busy_flag == (state != ATWC_IDLE);
	endproperty
	a_busy_state: assert property (p_busy_state) else $error("busy flag wrong");

	property p_no_sync;
		state == ATWC_IDLE && !sw_calc_start && !angle_sync_calc_enable |=> state == ATWC_IDLE;
	endproperty
	a_no_sync: assert property (p_no_sync) else $error("unsynced start");

	property p_irq_src;
		(angle_irq_source_sel ? calc_done : angle_step) && !wr_calc |=> angle_irq;
	endproperty
	a_irq_src: assert property (p_irq_src) else $error("angle irq missed");

	property p_count_up;
		angle_step && !angle_set && !timer_stop && !angle_count_direction
		&& electrical_angle_value != `ATWC_ANGLE_LAST
		|=> electrical_angle_value == $past(electrical_angle_value) + 9'h001;
	endproperty
	a_count_up: assert property (p_count_up) else $error("count up wrong");

	property p_tick_mask;
		presc_tick |-> prescale[2:0] == 3'h7 && angle_timer_enable;
	endproperty
	a_tick_mask: assert property (p_tick_mask) else $error("bad prescale tick");

	property p_xfer_off;
		!result_transfer_enable && state == ATWC_PH_W |=> !duty_load;
	endproperty
	a_xfer_off: assert property (p_xfer_off) else $error("load without enable");

	property p_calc_off;
		!waveform_calc_enable && state == ATWC_IDLE |=> state == ATWC_IDLE;
	endproperty
	a_calc_off: assert property (p_calc_off) else $error("calc while disabled");

	property p_timer_off;
		angle_timer_enable && timer_stop |=> electrical_angle_value == 9'h000 && period_cnt == 8'h00;
	endproperty
	a_timer_off: assert property (p_timer_off) else $error("timer not cleared");

	property p_busy_len;
		calc_trig |=> calc_busy_flag [*3] ##1 !calc_busy_flag && calc_done;
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("busy length wrong");

	c_sync_calc: cover property (sync_trig && calc_trig);
	c_three_phase: cover property (modulation_type_sel && duty_load);
	c_count_down: cover property (angle_step && angle_count_direction);
	c_irq: cover property (irq);

endmodule : atwc_ctrl

/* bench/atwc_pwm_model.sv */
// Far-side model of the PWM phase compare registers
`timescale 1ns/1ps
`include "atwc_cfg.svh"
module atwc_pwm_model (
	input  wire logic                    mclk,
	input  wire logic                    rst_n,
	input  wire logic                    load,
	input  wire logic [`ATWC_DUTY_W-1:0] u,
	input  wire logic [`ATWC_DUTY_W-1:0] v,
	input  wire logic [`ATWC_DUTY_W-1:0] w,
	output logic      [`ATWC_DUTY_W-1:0] cmp_u,
	output logic      [`ATWC_DUTY_W-1:0] cmp_v,
	output logic      [`ATWC_DUTY_W-1:0] cmp_w,
	output int                           loads
);
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cmp_u <= '0;
			cmp_v <= '0;
			cmp_w <= '0;
			loads <= 0;
		end else if (load) begin
			cmp_u <= u;
			cmp_v <= v;
			cmp_w <= w;
			loads <= loads + 1;
		end
	end
endmodule : atwc_pwm_model

/* bench/tb_angle_timer_waveform_ctrl.sv */
// Self-checking bench for the angle timer and waveform control block
`timescale 1ns/1ps
`include "atwc_cfg.svh"
module tb_angle_timer_waveform_ctrl;
	logic        mclk = 0;
	logic        rst_n = 0;
	logic        wr_en = 0;
	logic        rd_en = 0;
	logic [12:0] addr = '0;
	logic [7:0]  wr_data = '0;
	logic [7:0]  d;
	wire  [7:0]  rd_data;
	wire         irq;
	wire         angle_irq;
	wire         duty_load;
	wire  [9:0]  du, dv, dw, cu, cv, cw;
	int          loads, mismatches = 0, checked = 0, n_ang = 0, n, l;
	logic [7:0]  tab [3] = '{8'h40, 8'h80, 8'hff};

	atwc_ctrl uut (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
		.rd_data(rd_data), .irq(irq), .angle_irq(angle_irq), .phase_duty_compare_u(du),
		.phase_duty_compare_v(dv), .phase_duty_compare_w(dw), .duty_load(duty_load));
	atwc_pwm_model pwm (.mclk(mclk), .rst_n(rst_n), .load(duty_load), .u(du), .v(dv), .w(dw),
		.cmp_u(cu), .cmp_v(cv), .cmp_w(cw), .loads(loads));

	always #12.5 mclk = ~mclk;
	always @(posedge mclk) if (angle_irq === 1'b1) n_ang++;

	task print_verdict;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : print_verdict
	task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task wr(input logic [12:0] a, input logic [7:0] v);
		@(posedge mclk);
		addr <= a;
		wr_data <= v;
		wr_en <= 1'b1;
		@(posedge mclk);
		wr_en <= 1'b0;
	endtask : wr
	task rd(input logic [12:0] a, output logic [7:0] v);
		@(posedge mclk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge mclk);
		rd_en <= 1'b0;
		#1 v = rd_data;
	endtask : rd
	task tick(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask : tick
	// Bounded wait for angle_irq (sel 1) or duty_load (sel 0)
	task wait_hi(input bit sel, output int k);
		k = 0;
		do begin
			@(posedge mclk);
			#1 k++;
		end while (((sel ? angle_irq : duty_load) !== 1'b1) && k < 2000);
		if (k >= 2000) begin
			mismatches++;
			$display("BAD wait for pulse timed out");
			print_verdict;
		end
	endtask : wait_hi
	task set_angle(input logic [8:0] a);
		wr(`ATWC_ANG_HI_ADDR, {7'h00, a[8]});
		wr(`ATWC_ANG_LO_ADDR, a[7:0]);
	endtask : set_angle
	// Amplitude and period value are both 0x80
	function logic [9:0] ex(input logic [7:0] t, input bit three, input bit plus);
		logic [15:0] p;
		p = t * 16'h0080;
		if (!three) return 10'(p >> 8);
		if (plus) return 10'h080 + 10'(p >> 9);
		return (p >> 9) > 16'h0080 ? 10'h000 : 10'(16'h0080 - (p >> 9));
	endfunction : ex

	task t_reset;
		rd(`ATWC_MAIN_ADDR, d);
		chk("main ctrl", d, 16'h0000);
		rd(`ATWC_CALC_ADDR, d);
		chk("calc ctrl", d[3:0], 16'h0000);
		rd(13'h1fca, d);
		chk("unmapped", d, 16'h0000);
	endtask : t_reset
	task t_disabled;
		wr(`ATWC_CALC_ADDR, 8'h08);
		tick(1);
		rd(`ATWC_CALC_ADDR, d);
		chk("busy off", d[2], 16'h0000);
		tick(6);
		chk("no load", loads, 16'h0000);
	endtask : t_disabled
	task t_table;
		for (int i = 0; i < 3; i++) begin
			set_angle(9'(i * 128));
			wr(`ATWC_WAVE_ADDR, tab[i]);
		end
		wr(`ATWC_AMP_ADDR, 8'h80);
		wr(`ATWC_PRD_ADDR, 8'h80);
		set_angle(9'h000);
	endtask : t_table
	task t_calc(input logic [7:0] m, input logic [9:0] eu, ev, ew);
		wr(`ATWC_MAIN_ADDR, m);
		l = n_ang;
		wr(`ATWC_CALC_ADDR, 8'h09);
		rd(`ATWC_CALC_ADDR, d);
		chk("busy on", d[2], 16'h0001);
		wait_hi(0, n);
		tick(3);
		chk("duty u", cu, eu);
		chk("duty v", cv, ev);
		chk("duty w", cw, ew);
		chk("calc end irq", n_ang - l, 16'h0001);
		rd(`ATWC_CALC_ADDR, d);
		chk("busy done", d[3:2], 16'h0000);
	endtask : t_calc
	task t_noxfer;
		wr(`ATWC_MAIN_ADDR, 8'h02);
		l = loads;
		wr(`ATWC_CALC_ADDR, 8'h08);
		tick(8);
		chk("no transfer", loads - l, 16'h0000);
		wr(`ATWC_CALC_ADDR, 8'h00);
		tick(6);
		chk("zero start", loads - l, 16'h0000);
	endtask : t_noxfer
	task t_sync;
		wr(`ATWC_MAIN_ADDR, 8'h06);
		wr(`ATWC_CALC_ADDR, 8'h02);
		l = loads;
		set_angle(9'h000);
		wait_hi(0, n);
		tick(1);
		chk("sync load", loads - l, 16'h0001);
		wr(`ATWC_CALC_ADDR, 8'h00);
		set_angle(9'h000);
		tick(8);
		chk("no sync", loads - l, 16'h0001);
	endtask : t_sync
	task t_timer;
		wr(`ATWC_MAIN_ADDR, 8'h00);
		wr(`ATWC_EDT_ADDR, 8'h00);
		for (int c = 0; c < 4; c++) begin
			wr(`ATWC_MAIN_ADDR, 8'(c << 4));
			wr(`ATWC_MAIN_ADDR, 8'(c << 4) | 8'h01);
			wait_hi(1, n);
			wait_hi(1, n);
			chk("tick interval", n, 16'(8 << c));
			if (c < 3) wr(`ATWC_MAIN_ADDR, 8'(c << 4));
		end
		rd(`ATWC_ANG_LO_ADDR, d);
		chk("angle up", d, 16'h0002);
		wr(`ATWC_MAIN_ADDR, 8'h30);
		rd(`ATWC_ANG_LO_ADDR, d);
		chk("angle cleared", d, 16'h0000);
		wr(`ATWC_MAIN_ADDR, 8'hb1);
		wait_hi(1, n);
		rd(`ATWC_ANG_LO_ADDR, d);
		chk("angle down lo", d, 16'h007f);
		rd(`ATWC_ANG_HI_ADDR, d);
		chk("angle down hi", d[0], 16'h0001);
		wr(`ATWC_MAIN_ADDR, 8'hb0);
	endtask : t_timer
	task t_irq;
		wr(`ATWC_MASK_ADDR, 8'h00);
		tick(2);
		chk("irq masked", irq, 16'h0000);
		rd(`ATWC_STAT_ADDR, d);
		chk("status", d, 16'h0003);
		for (int b = 1; b >= 0; b--) begin
			wr(`ATWC_MASK_ADDR, 8'(1 << b));
			tick(2);
			chk("irq on", irq, 16'h0001);
			wr(`ATWC_STAT_ADDR, 8'(1 << b));
			tick(2);
			chk("irq off", irq, 16'h0000);
		end
	endtask : t_irq

	initial begin
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		t_reset;
		t_disabled;
		t_table;
		t_calc(8'h06, ex(tab[0], 0, 1), ex(tab[1], 0, 1), ex(tab[2], 0, 1));
		t_calc(8'h46, ex(tab[0], 0, 1), ex(tab[2], 0, 1), ex(tab[1], 0, 1));
		t_calc(8'h0e, ex(tab[0], 1, 1), ex(tab[1], 1, 1), ex(tab[2], 1, 0));
		t_calc(8'h4e, ex(tab[0], 1, 1), ex(tab[2], 1, 0), ex(tab[1], 1, 1));
		t_noxfer;
		t_sync;
		t_timer;
		t_irq;
		print_verdict;
	end
endmodule : tb_angle_timer_waveform_ctrl
